/* verilog/psa_sample_offcore.sv */
// Sample address capture and offcore request filter with AXI4-Lite registers
// Notes on behaviour
// - Any of counters 0-3 may profile addresses
// - Enabled counter overflow starts a sample record; dropped here while a pending record waits on record_ready
// - Overflow latches retiring memory uop address, status
// - Latched data goes into the following record; here it goes into the record started by the same overflow
// - Enable bit makes counter precise, enables profiling
// - Entries 98H, A0H, A8H filled; A8H zero
// - Entry 98H holds load or store address
// - Store status bit 0 is first-level hit
// - Hit bit meaningful only for store events
// - Entry B0H holds triggering instruction pointer
// - Entry 08H holds next instruction pointer
// - Filter: type 15:0, supplier 30:16, snoop 37:31
// - Type bit 0 counts demand data reads
// - Type bit 1 counts demand ownership reads
// - Type bit 2 counts demand code reads
// - Bits 4-6 count second-level prefetch classes
// - Type bit 15 counts any other request
// - Defined type bits are read/write
// - Record format independent of 64-bit mode
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
module psa_sample_offcore (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        clk_en,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [3:0]                  ctr_overflow,
  input  wire psa_pkg::psa_retire_type     retire,
  output psa_pkg::psa_record_type          record,
  output logic                             record_valid,
  input  wire logic                        record_ready,
  input  wire logic                        req_valid,
  input  wire psa_pkg::psa_req_class_type  req_class,
  output logic                             offcore_hit
);

  // ==========================================================
  // Functions
  function automatic logic [31:0] apply_strobe(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strobe

  function automatic logic [1:0] lowest_index(input logic [3:0] hits);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = psa_pkg::NUM_SAMPLE_CTRS - 1; i >= 0; i--) begin
      if (hits[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : lowest_index

  function automatic logic [3:0] class_bit(
      input psa_pkg::psa_req_class_type cls);
    case (cls)
      psa_pkg::REQ_DEMAND_DATA: class_bit = 4'h0;
      psa_pkg::REQ_DEMAND_OWN:  class_bit = 4'h1;
      psa_pkg::REQ_DEMAND_CODE: class_bit = 4'h2;
      psa_pkg::REQ_L2PF_DATA:   class_bit = 4'h4;
      psa_pkg::REQ_L2PF_OWN:    class_bit = 4'h5;
      psa_pkg::REQ_L2PF_CODE:   class_bit = 4'h6;
      psa_pkg::REQ_OTHER:       class_bit = 4'hF;
      default:                  class_bit = 4'h3;
    endcase
  endfunction : class_bit

  // ==========================================================
  // State
  logic [3:0]              sample_en_reg;
  logic [37:0]             filter_reg;
  logic [31:0]             match_count_reg;
  logic [15:0]             sample_count_reg;
  logic [63:0]             last_addr_reg;
  logic                    aw_held_reg;
  logic [7:0]              awaddr_reg;
  logic                    w_held_reg;
  logic [31:0]             wdata_reg;
  logic [3:0]              wstrb_reg;
  logic                    aw_held_next;
  logic                    w_held_next;
  logic                    bvalid_next;
  logic                    do_write;
  logic                    wr_ok;
  logic [3:0]              ovf_hits;
  logic                    rec_slot_free;
  logic                    take_sample;
  logic [15:0]             req_type_eff;
  logic [31:0]             en_word;
  logic [31:0]             lo_word;
  logic [31:0]             hi_word;
  logic                    filter_match;

  // ==========================================================
  // Sample capture
  assign ovf_hits      = ctr_overflow & sample_en_reg;
  assign rec_slot_free = !record_valid || record_ready;
  assign take_sample   = clk_en && (ovf_hits != 4'h0) && rec_slot_free;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      record_valid <= 1'b0;
    end else if (clk_en) begin
      if (ovf_hits != 4'h0 && rec_slot_free) begin
        record_valid <= 1'b1;
      end else if (record_ready) begin
        record_valid <= 1'b0;
      end
    end
  end

  // Full 64-bit entries regardless of operating mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      record <= '0;
    end else if (take_sample) begin
      record.ctr_idx      <= lowest_index(ovf_hits);
      record.lin_addr     <= retire.lin_addr;
      record.store_status <= {63'h0, retire.is_store
                              & retire.l1_hit};
      record.reserved_a8  <= 64'h0;
      record.eventing_ip  <= retire.instr_ip;
      record.next_ip      <= retire.next_ip;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_count_reg <= 16'h0000;
      last_addr_reg    <= 64'h0000_0000_0000_0000;
    end else if (take_sample) begin
      sample_count_reg <= sample_count_reg + 16'h0001;
      last_addr_reg    <= retire.lin_addr;
    end
  end

  // ==========================================================
  // Offcore request filter
  assign req_type_eff = filter_reg[psa_pkg::REQ_TYPE_MSB:
                                   psa_pkg::REQ_TYPE_LSB]
                        & psa_pkg::REQ_TYPE_DEFINED;
  assign filter_match = req_type_eff[class_bit(req_class)];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offcore_hit <= 1'b0;
    end else if (clk_en) begin
      offcore_hit <= req_valid && filter_match;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_count_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (offcore_hit) begin
        match_count_reg <= match_count_reg + 32'h0000_0001;
      end else if (do_write && awaddr_reg == psa_pkg::ADDR_MATCH_COUNT) begin
        match_count_reg <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    bvalid_next  = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_comb begin
    case (awaddr_reg)
      psa_pkg::ADDR_SAMPLE_EN,
      psa_pkg::ADDR_STATUS,
      psa_pkg::ADDR_LAST_LO,
      psa_pkg::ADDR_LAST_HI,
      psa_pkg::ADDR_OFFCORE_LO,
      psa_pkg::ADDR_OFFCORE_HI,
      psa_pkg::ADDR_MATCH_COUNT: wr_ok = 1'b1;
      default:                   wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bresp   <= psa_pkg::RESP_OKAY;
    end else if (clk_en) begin
      aw_held_reg   <= aw_held_next;
      w_held_reg    <= w_held_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_awready <= !aw_held_next && !bvalid_next;
      s_axi_wready  <= !w_held_next && !bvalid_next;
      if (do_write) begin
        s_axi_bresp <= wr_ok ? psa_pkg::RESP_OKAY : psa_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Register updates from software
  assign en_word = apply_strobe({28'h0, sample_en_reg}, wdata_reg, wstrb_reg);
  assign lo_word = apply_strobe(filter_reg[31:0], wdata_reg, wstrb_reg);
  assign hi_word = apply_strobe({26'h0, filter_reg[37:32]},
                                wdata_reg, wstrb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_en_reg <= psa_pkg::SAMPLE_EN_RESET;
      filter_reg    <= psa_pkg::FILTER_RESET;
    end else if (clk_en && do_write) begin
      case (awaddr_reg)
        psa_pkg::ADDR_SAMPLE_EN: begin
          sample_en_reg <= en_word[3:0];
        end
        psa_pkg::ADDR_OFFCORE_LO: begin
          filter_reg[31:0] <= lo_word;
        end
        psa_pkg::ADDR_OFFCORE_HI: begin
          filter_reg[37:32] <= hi_word[5:0];
        end
        default: begin
          sample_en_reg <= sample_en_reg;
        end
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic [31:0] rd_word;
  logic        rd_ok;

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      psa_pkg::ADDR_SAMPLE_EN:   rd_word = {28'h0, sample_en_reg};
      psa_pkg::ADDR_STATUS: begin
        rd_word[psa_pkg::STATUS_PENDING_BIT] = record_valid;
        rd_word[psa_pkg::STATUS_IDX_LSB +: 2] = record.ctr_idx;
        rd_word[psa_pkg::STATUS_COUNT_LSB +: 16] = sample_count_reg;
      end
      psa_pkg::ADDR_LAST_LO:     rd_word = last_addr_reg[31:0];
      psa_pkg::ADDR_LAST_HI:     rd_word = last_addr_reg[63:32];
      psa_pkg::ADDR_OFFCORE_LO:  rd_word = filter_reg[31:0];
      psa_pkg::ADDR_OFFCORE_HI:  rd_word = {26'h0, filter_reg[37:32]};
      psa_pkg::ADDR_MATCH_COUNT: rd_word = match_count_reg;
      default:                   rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= psa_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? psa_pkg::RESP_OKAY : psa_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Assertions
  a_overflow_starts_record: assert property (
    @(posedge aclk) disable iff (!aresetn)
    take_sample |=> record_valid)
    else $error("enabled overflow did not raise a record");

  a_disabled_no_record: assert property (
    @(posedge aclk) disable iff (!aresetn)
    clk_en && !record_valid && (ctr_overflow & sample_en_reg) == 4'h0
    |=> !record_valid)
    else $error("record raised without enabled overflow");

  a_address_latched: assert property (
    @(posedge aclk) disable iff (!aresetn)
    take_sample |=> record.lin_addr == $past(retire.lin_addr)
                    && last_addr_reg == $past(retire.lin_addr))
    else $error("record address differs from retiring uop");

  a_store_hit_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    take_sample && retire.is_store
    |=> record.store_status[psa_pkg::STORE_HIT_BIT] == $past(retire.l1_hit))
    else $error("store hit bit wrong");

  a_reserved_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    record_valid |-> record.reserved_a8 == 64'h0
                     && record.store_status[63:1] == 63'h0)
    else $error("reserved record entry not zero");

  a_ip_fields: assert property (
    @(posedge aclk) disable iff (!aresetn)
    take_sample |=> record.eventing_ip == $past(retire.instr_ip)
                    && record.next_ip == $past(retire.next_ip))
    else $error("instruction pointers not captured");

  a_record_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    record_valid && !record_ready |=> record_valid && $stable(record))
    else $error("pending record changed before taken");

  a_lowest_counter: assert property (
    @(posedge aclk) disable iff (!aresetn)
    take_sample && ovf_hits[0] |=> record.ctr_idx == 2'h0)
    else $error("wrong counter index in record");

  a_reserved_no_count: assert property (
    @(posedge aclk) disable iff (!aresetn)
    clk_en && req_valid && class_bit(req_class) == 4'h3 |=> !offcore_hit)
    else $error("reserved type bit produced a hit");

  a_offcore_follows: assert property (
    @(posedge aclk) disable iff (!aresetn)
    clk_en && req_valid && req_class == psa_pkg::REQ_DEMAND_DATA
    |=> offcore_hit == $past(filter_reg[0]))
    else $error("demand data read hit mismatch");

endmodule : psa_sample_offcore

/* include/psa_pkg.sv */
// Package: constants and carriers for the sample-address and offcore block
package psa_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_SAMPLE_EN   = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_LAST_LO     = 8'h08;
  localparam logic [7:0] ADDR_LAST_HI     = 8'h0C;
  localparam logic [7:0] ADDR_OFFCORE_LO  = 8'h10;
  localparam logic [7:0] ADDR_OFFCORE_HI  = 8'h14;
  localparam logic [7:0] ADDR_MATCH_COUNT = 8'h18;

  // ==========================================================
  // Field layouts and reset values
  localparam int          NUM_SAMPLE_CTRS    = 4;
  localparam int          FILTER_WIDTH       = 38;
  localparam int          REQ_TYPE_LSB       = 0;
  localparam int          REQ_TYPE_MSB       = 15;
  localparam int          SUPPLIER_LSB       = 16;
  localparam int          SUPPLIER_MSB       = 30;
  localparam int          SNOOP_LSB          = 31;
  localparam int          SNOOP_MSB          = 37;
  localparam int          FILTER_HI_WIDTH    = FILTER_WIDTH - 32;
  localparam logic [15:0] REQ_TYPE_DEFINED   = 16'h8077;
  localparam logic [3:0]  SAMPLE_EN_RESET    = 4'h0;
  localparam logic [37:0] FILTER_RESET       = 38'h00_0000_0000;
  localparam int          STORE_HIT_BIT      = 0;
  localparam int          STATUS_PENDING_BIT = 0;
  localparam int          STATUS_IDX_LSB     = 4;
  localparam int          STATUS_COUNT_LSB   = 16;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // ==========================================================
  // Offcore request classes
  typedef enum logic [2:0] {
    REQ_DEMAND_DATA = 3'h0,
    REQ_DEMAND_OWN  = 3'h1,
    REQ_DEMAND_CODE = 3'h2,
    REQ_L2PF_DATA   = 3'h3,
    REQ_L2PF_OWN    = 3'h4,
    REQ_L2PF_CODE   = 3'h5,
    REQ_OTHER       = 3'h6
  } psa_req_class_type;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        is_store;
    logic        l1_hit;
    logic [63:0] lin_addr;
    logic [63:0] instr_ip;
    logic [63:0] next_ip;
  } psa_retire_type;

  // Record entries at 98H, A0H, A8H, B0H and 08H
  typedef struct packed {
    logic [1:0]  ctr_idx;
    logic [63:0] lin_addr;
    logic [63:0] store_status;
    logic [63:0] reserved_a8;
    logic [63:0] eventing_ip;
    logic [63:0] next_ip;
  } psa_record_type;

endpackage : psa_pkg

/* sim/psa_sample_offcore_test.sv */
// Testbench for the sample address and offcore filter block
module psa_sample_offcore_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic                       aclk;
  logic                       aresetn;
  logic                       clk_en;
  logic [7:0]                 s_axi_awaddr;
  logic                       s_axi_awvalid;
  logic                       s_axi_awready;
  logic [31:0]                s_axi_wdata;
  logic [3:0]                 s_axi_wstrb;
  logic                       s_axi_wvalid;
  logic                       s_axi_wready;
  logic [1:0]                 s_axi_bresp;
  logic                       s_axi_bvalid;
  logic                       s_axi_bready;
  logic [7:0]                 s_axi_araddr;
  logic                       s_axi_arvalid;
  logic                       s_axi_arready;
  logic [31:0]                s_axi_rdata;
  logic [1:0]                 s_axi_rresp;
  logic                       s_axi_rvalid;
  logic                       s_axi_rready;
  logic [3:0]                 ctr_overflow;
  psa_pkg::psa_retire_type    retire;
  psa_pkg::psa_record_type    record;
  logic                       record_valid;
  logic                       record_ready;
  logic                       req_valid;
  psa_pkg::psa_req_class_type req_class;
  logic                       offcore_hit;
  int                         num_errors;
  int                         check_count;

  // ==========================================================
  // Design under test
  psa_sample_offcore i_psa_sample_offcore (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .clk_en        (clk_en),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ctr_overflow  (ctr_overflow),
    .retire        (retire),
    .record        (record),
    .record_valid  (record_valid),
    .record_ready  (record_ready),
    .req_valid     (req_valid),
    .req_class     (req_class),
    .offcore_hit   (offcore_hit)
  );

  // ==========================================================
  // Clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    complete_run();
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed);
    check(s_axi_rresp, er);
  endtask : axi_read

  // One overflow with a distinct retiring uop per case
  task automatic sample(input int k, input logic [3:0] en,
                        input logic [3:0] ovf, input logic take,
                        input logic [1:0] idx);
    logic [63:0] la;
    la = 64'h8000_1234_0000_0040 + 64'(k * 8);
    axi_write(psa_pkg::ADDR_SAMPLE_EN, {28'h0, en},
              psa_pkg::RESP_OKAY);
    @(posedge aclk);
    retire <= '{is_store: k[0], l1_hit: k[1], lin_addr: la,
                instr_ip: la ^ 64'h0F0F, next_ip: la ^ 64'hF0F0};
    ctr_overflow <= ovf;
    @(posedge aclk);
    ctr_overflow <= 4'h0;
    #1;
    check(record_valid, take);
    if (take) begin
      check(record.ctr_idx, idx);
      check(record.lin_addr, la);
      check(record.reserved_a8, 64'h0);
      check(record.eventing_ip, la ^ 64'h0F0F);
      check(record.next_ip, la ^ 64'hF0F0);
      if (k[0]) check(record.store_status, {63'h0, k[1]});
      @(posedge aclk);
      record_ready <= 1'b1;
      @(posedge aclk);
      record_ready <= 1'b0;
      #1;
      check(record_valid, 1'b0);
      axi_read(psa_pkg::ADDR_LAST_LO, la[31:0], psa_pkg::RESP_OKAY);
      axi_read(psa_pkg::ADDR_LAST_HI, la[63:32], psa_pkg::RESP_OKAY);
    end
  endtask : sample

  // ==========================================================
  // Main sequence
  initial begin
    int          pos [7];
    logic [15:0] mask;
    pos = '{0, 1, 2, 4, 5, 6, 15};
    num_errors = 0;
    check_count = 0;
    aresetn = 1'b0;
    clk_en = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    ctr_overflow = 4'h0;
    retire = '0;
    record_ready = 1'b0;
    req_valid = 1'b0;
    req_class = psa_pkg::REQ_DEMAND_DATA;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset values, unmapped and read-only places
    axi_read(psa_pkg::ADDR_SAMPLE_EN, 32'h0, psa_pkg::RESP_OKAY);
    axi_read(psa_pkg::ADDR_OFFCORE_LO, 32'h0, psa_pkg::RESP_OKAY);
    axi_read(psa_pkg::ADDR_OFFCORE_HI, 32'h0, psa_pkg::RESP_OKAY);
    axi_read(8'h1C, 32'h0, psa_pkg::RESP_SLVERR);
    axi_write(8'h1C, 32'hFFFF_FFFF, psa_pkg::RESP_SLVERR);
    axi_write(psa_pkg::ADDR_OFFCORE_HI, 32'hFFFF_FFEA,
              psa_pkg::RESP_OKAY);
    axi_read(psa_pkg::ADDR_OFFCORE_HI, 32'h0000_002A,
             psa_pkg::RESP_OKAY);
    // Sampling on each counter, lowest index wins, disabled counter ignored
    sample(0, 4'h1, 4'hF, 1'b1, 2'd0);
    sample(1, 4'h2, 4'hF, 1'b1, 2'd1);
    sample(2, 4'h4, 4'hF, 1'b1, 2'd2);
    sample(3, 4'h8, 4'hF, 1'b1, 2'd3);
    sample(5, 4'hF, 4'hC, 1'b1, 2'd2);
    sample(4, 4'h4, 4'h3, 1'b0, 2'd0);
    // Clock enable low freezes sampling
    @(posedge aclk);
    clk_en       <= 1'b0;
    ctr_overflow <= 4'h4;
    repeat (3) @(posedge aclk);
    clk_en       <= 1'b1;
    ctr_overflow <= 4'h0;
    #1;
    check(record_valid, 1'b0);
    // Status is read-only: pending, last index, sample count
    axi_write(psa_pkg::ADDR_STATUS, 32'hFFFF_FFFF,
              psa_pkg::RESP_OKAY);
    axi_read(psa_pkg::ADDR_STATUS, 32'h0005_0020,
             psa_pkg::RESP_OKAY);
    // Request-type filter: each class bit, then reserved bits only
    axi_write(psa_pkg::ADDR_MATCH_COUNT, 32'h0, psa_pkg::RESP_OKAY);
    for (int s = 0; s < 8; s++) begin
      mask = (s < 7) ? 16'(1 << pos[s]) : 16'h7F88;
      axi_write(psa_pkg::ADDR_OFFCORE_LO, {16'hFFFF, mask},
                psa_pkg::RESP_OKAY);
      axi_read(psa_pkg::ADDR_OFFCORE_LO, {16'hFFFF, mask},
               psa_pkg::RESP_OKAY);
      for (int c = 0; c < 8; c++) begin
        @(posedge aclk);
        req_valid <= 1'b1;
        req_class <= psa_pkg::psa_req_class_type'(c[2:0]);
        @(posedge aclk);
        req_valid <= 1'b0;
        #1;
        check(offcore_hit, (s == c) && (s < 7));
      end
    end
    axi_read(psa_pkg::ADDR_MATCH_COUNT, 32'd7, psa_pkg::RESP_OKAY);
    complete_run();
  end

endmodule : psa_sample_offcore_test
